/* hdl/pmev_debounce.sv */
// Purpose: settle a synchronised level over a fixed count of cycles
// Assumes: din already synchronised to clk
// Notes: chg_r pulses one cycle when q_r takes a new value
`timescale 1ns/100ps
`default_nettype none

module pmev_debounce #(
  parameter int unsigned CYCLES = 1600000,
  parameter int CNT_W = 21
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic q_r,
  output logic chg_r
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire differ = din != q_r;
  wire done = cnt_r == CNT_W'(CYCLES - 1);

  // count only while input disagrees with settled level
  assign cnt_nxt = (!differ || done) ? '0 : cnt_r + CNT_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      q_r <= 1'b1;
      chg_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      q_r <= (differ && done) ? din : q_r;
      chg_r <= differ && done;
    end
  end

  property p_settle;
    @(posedge clk) disable iff (!rst_n)
    (q_r != $past(q_r)) |-> $past(cnt_r) == CNT_W'(CYCLES - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("level changed before settling");

endmodule

`default_nettype wire

/* hdl/pmev_top.sv */
// Purpose: power event inputs, management interrupt and clock stop requests
// Assumes: APB slave on pclk; resume_well_reset_n also clears event logic
// Notes: pready answers in the first access cycle, no wait states
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "pmev_consts.svh"

module pmev_top #(
  parameter int unsigned DEBOUNCE_CYCLES = `PMEV_DEBOUNCE_CYC,
  parameter int DEB_CNT_W = 21
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic resume_well_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMEV_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic battery_low_n,
  input wire logic lid_in,
  input wire logic power_button_n,
  input wire logic ring_wake_n,
  input wire logic [3:0] bus_master_req_monitor_n,
  input wire logic ext_mgmt_irq_req_n_i,
  output logic ext_mgmt_irq_req_n_o,
  output logic ext_mgmt_irq_req_n_oe,
  input wire logic serirq_mgmt_irq,
  output logic mgmt_irq_out_n,
  output logic resume_wake,
  output logic proc_clock_stop_n,
  output logic bus_clock_stop_n
);

  ////////////////////////////////////////////////////////////////////////
  // resets and synchronisers

  wire rst_well_n = presetn & resume_well_reset_n;
  logic [`PMEV_NSYNC-1:0] meta_r;
  logic [`PMEV_NSYNC-1:0] sync_r;
  wire [`PMEV_NSYNC-1:0] async_in = {bus_master_req_monitor_n, ext_mgmt_irq_req_n_i,
                                     ring_wake_n, power_button_n, lid_in, battery_low_n};

  always_ff @(posedge pclk or negedge rst_well_n) begin
    if (!rst_well_n) begin
      meta_r <= `PMEV_SYNC_RST;
      sync_r <= `PMEV_SYNC_RST;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  wire bat_low = !sync_r[`PMEV_S_BAT];
  wire ext_s = sync_r[`PMEV_S_EXT];
  wire [3:0] bm_s = sync_r[`PMEV_S_BM +: 4];

  ////////////////////////////////////////////////////////////////////////
  // debounce of lid and power button

  logic [1:0] deb_q;
  logic [1:0] deb_chg;
  wire [1:0] deb_in = {sync_r[`PMEV_S_PWR], sync_r[`PMEV_S_LID]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_deb
      pmev_debounce #(
        .CYCLES(DEBOUNCE_CYCLES),
        .CNT_W(DEB_CNT_W)
      ) u_deb (
        .clk(pclk),
        .rst_n(rst_well_n),
        .din(deb_in[gi]),
        .q_r(deb_q[gi]),
        .chg_r(deb_chg[gi])
      );
    end
  endgenerate

  wire lid_chg = deb_chg[0];
  wire pwr_press = deb_chg[1] && !deb_q[1];

  ////////////////////////////////////////////////////////////////////////
  // external request edge detector and ring edge

  logic [2:0] hi_cnt_r;
  logic [2:0] hi_cnt_nxt;
  logic ring_d_r;
  wire ext_armed = hi_cnt_r == `PMEV_REARM_CLKS;
  wire ext_fall = ext_armed && !ext_s;
  wire ring_fall = ring_d_r && !sync_r[`PMEV_S_RING];
  wire bm_active = bm_s != 4'hF;

  // rearm only after enough high samples
  assign hi_cnt_nxt = !ext_s ? 3'h0 : (ext_armed ? hi_cnt_r : hi_cnt_r + 3'h1);

  always_ff @(posedge pclk or negedge rst_well_n) begin
    if (!rst_well_n) begin
      hi_cnt_r <= 3'h0;
      ring_d_r <= 1'b1;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      ring_d_r <= sync_r[`PMEV_S_RING];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [`PMEV_CTRL_W-1:0] ctrl_r;
  logic [`PMEV_ST_W-1:0] status_r;
  logic [`PMEV_ST_W-1:0] status_nxt;
  pmev_pkg::pmev_clk_e cs_r;
  pmev_pkg::pmev_clk_e cs_nxt;

  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire hit_ctrl = paddr == `PMEV_OFF_CTRL;
  wire hit_status = paddr == `PMEV_OFF_STATUS;
  wire hit_pins = paddr == `PMEV_OFF_PINS;
  wire mapped = hit_ctrl || hit_status || hit_pins;
  wire wr_ctrl = access && pwrite && hit_ctrl && !pslverr;
  wire wr_status = access && pwrite && hit_status && !pslverr;
  wire [`PMEV_ST_W-1:0] st_clr = wr_status ? pwdata[`PMEV_ST_W-1:0] : '0;

  // pin image: battery low, lid, ring, power button, requests, clock state
  wire [31:0] pins_word = {21'h0, cs_r, bm_s, deb_q[1], sync_r[`PMEV_S_RING], deb_q[0],
                           sync_r[`PMEV_S_BAT]};
  wire [31:0] rd_word = hit_ctrl ? {21'h0, ctrl_r} :
                        hit_status ? {27'h0, status_r} :
                        hit_pins ? pins_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? rd_word : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `PMEV_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[`PMEV_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over write-one clear

  wire [`PMEV_ST_W-1:0] st_set = {bm_active, ring_fall, pwr_press, lid_chg, ext_fall};
  assign status_nxt = (status_r & ~st_clr) | st_set;

  always_ff @(posedge pclk or negedge rst_well_n) begin
    if (!rst_well_n) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt, wake and open-drain request line

  wire [`PMEV_ST_W-1:0] smi_en = {2'b00, ctrl_r[`PMEV_C_PWR_EN], ctrl_r[`PMEV_C_LID_EN],
                                  ctrl_r[`PMEV_C_EXT_EN]};
  wire smi_nxt = |(status_nxt & smi_en & `PMEV_SMI_SRC_MASK);
  wire resume_blk = ctrl_r[`PMEV_C_BAT_BLK] && bat_low;
  wire wake_src = (ring_fall && ctrl_r[`PMEV_C_RING_EN]) || pwr_press;

  always_ff @(posedge pclk or negedge rst_well_n) begin
    if (!rst_well_n) begin
      mgmt_irq_out_n <= 1'b1;
      resume_wake <= 1'b0;
      ext_mgmt_irq_req_n_oe <= 1'b0;
      ext_mgmt_irq_req_n_o <= 1'b0;
    end else begin
      mgmt_irq_out_n <= !smi_nxt;
      resume_wake <= wake_src && !resume_blk;
      ext_mgmt_irq_req_n_oe <= serirq_mgmt_irq;
      ext_mgmt_irq_req_n_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock stop sequencer

  wire bus_fn = ctrl_r[`PMEV_C_BUS_FN];
  wire proc_fn = ctrl_r[`PMEV_C_PROC_FN];
  wire bus_req = ctrl_r[`PMEV_C_BUS_REQ] && bus_fn;
  wire proc_req = ctrl_r[`PMEV_C_PROC_REQ] && proc_fn;

  always_comb begin
    cs_nxt = cs_r;
    case (cs_r)
      pmev_pkg::PMEV_CS_RUN: begin
        if (bus_req && !bm_active) begin
          cs_nxt = pmev_pkg::PMEV_CS_BUS;
        end
      end
      pmev_pkg::PMEV_CS_BUS: begin
        if (!bus_req || bm_active) begin
          cs_nxt = pmev_pkg::PMEV_CS_RUN;
        end else if (proc_req) begin
          cs_nxt = pmev_pkg::PMEV_CS_PROC;
        end
      end
      pmev_pkg::PMEV_CS_PROC: begin
        if (!proc_req || bm_active) begin
          cs_nxt = pmev_pkg::PMEV_CS_BUS;
        end
      end
      default: cs_nxt = pmev_pkg::PMEV_CS_RUN;
    endcase
  end

  wire bus_stop_nxt = bus_fn ? (cs_nxt == pmev_pkg::PMEV_CS_RUN) : ctrl_r[`PMEV_C_GP_OUTPUT_EIGHTEEN];
  wire proc_stop_nxt = proc_fn ? (cs_nxt != pmev_pkg::PMEV_CS_PROC) :
                       ctrl_r[`PMEV_C_GP_OUTPUT_SEVENTEEN];

  always_ff @(posedge pclk or negedge rst_well_n) begin
    if (!rst_well_n) begin
      cs_r <= pmev_pkg::PMEV_CS_RUN;
      bus_clock_stop_n <= 1'b1;
      proc_clock_stop_n <= 1'b1;
    end else begin
      cs_r <= cs_nxt;
      bus_clock_stop_n <= bus_stop_nxt;
      proc_clock_stop_n <= proc_stop_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_ext_smi;
    @(posedge pclk) disable iff (!rst_well_n)
    (ext_fall && ctrl_r[`PMEV_C_EXT_EN] && !wr_ctrl) |=> !mgmt_irq_out_n ##0 status_r[0];
  endproperty
  a_ext_smi: assert property (p_ext_smi) else $error("ext request edge gave no interrupt");

  property p_rearm;
    @(posedge pclk) disable iff (!rst_well_n)
    ext_fall |-> $past(ext_s, 1) && $past(ext_s, 4);
  endproperty
  a_rearm: assert property (p_rearm) else $error("edge taken before four high clocks");

  property p_lid;
    @(posedge pclk) disable iff (!rst_well_n)
    (lid_chg && ctrl_r[`PMEV_C_LID_EN] && !wr_ctrl) |=> !mgmt_irq_out_n;
  endproperty
  a_lid: assert property (p_lid) else $error("lid change gave no interrupt");

  property p_batblk;
    @(posedge pclk) disable iff (!rst_well_n)
    resume_wake |-> !$past(resume_blk);
  endproperty
  a_batblk: assert property (p_batblk) else $error("wake while battery low block");

  property p_proc_stop;
    @(posedge pclk) disable iff (!rst_well_n)
    (proc_fn && cs_r == pmev_pkg::PMEV_CS_PROC) |-> !proc_clock_stop_n;
  endproperty
  a_proc_stop: assert property (p_proc_stop) else $error("proc clock not stopped");

  property p_proc_gpo;
    @(posedge pclk) disable iff (!rst_well_n)
    !proc_fn |=> proc_clock_stop_n == $past(ctrl_r[`PMEV_C_GP_OUTPUT_SEVENTEEN]);
  endproperty
  a_proc_gpo: assert property (p_proc_gpo) else $error("proc stop pin ignores output bit");

  property p_bus_stop;
    @(posedge pclk) disable iff (!rst_well_n)
    (bus_fn && cs_r != pmev_pkg::PMEV_CS_RUN) |-> !bus_clock_stop_n;
  endproperty
  a_bus_stop: assert property (p_bus_stop) else $error("bus clock not stopped");

  property p_serirq;
    @(posedge pclk) disable iff (!rst_well_n)
    serirq_mgmt_irq |=> ext_mgmt_irq_req_n_oe && !ext_mgmt_irq_req_n_o;
  endproperty
  a_serirq: assert property (p_serirq) else $error("ext line not pulled low");

  property p_bm_wake;
    @(posedge pclk) disable iff (!rst_well_n)
    (bm_active && cs_r == pmev_pkg::PMEV_CS_BUS) |=> cs_r == pmev_pkg::PMEV_CS_RUN ##1 1'b1;
  endproperty
  a_bm_wake: assert property (p_bm_wake) else $error("bus activity did not restart");

endmodule

`default_nettype wire

/* pkg/pmev_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, 100 MHz bus clock
// Notes: included by bare name
`ifndef PMEV_CONSTS_SVH
`define PMEV_CONSTS_SVH

// register byte offsets
`define PMEV_ADDR_W 12
`define PMEV_OFF_CTRL 12'h000
`define PMEV_OFF_STATUS 12'h004
`define PMEV_OFF_PINS 12'h008

// control fields
`define PMEV_CTRL_W 11
`define PMEV_C_EXT_EN 0
`define PMEV_C_LID_EN 1
`define PMEV_C_PWR_EN 2
`define PMEV_C_RING_EN 3
`define PMEV_C_BAT_BLK 4
`define PMEV_C_PROC_FN 5
`define PMEV_C_BUS_FN 6
`define PMEV_C_PROC_REQ 7
`define PMEV_C_BUS_REQ 8
`define PMEV_C_GP_OUTPUT_SEVENTEEN 9
`define PMEV_C_GP_OUTPUT_EIGHTEEN 10
`define PMEV_CTRL_RST 11'h600

// sticky status fields
`define PMEV_ST_W 5
`define PMEV_ST_EXT 0
`define PMEV_ST_LID 1
`define PMEV_ST_PWR 2
`define PMEV_ST_RING 3
`define PMEV_ST_BM 4
`define PMEV_SMI_SRC_MASK 5'h07

// synchroniser vector layout
`define PMEV_NSYNC 9
`define PMEV_S_BAT 0
`define PMEV_S_LID 1
`define PMEV_S_PWR 2
`define PMEV_S_RING 3
`define PMEV_S_EXT 4
`define PMEV_S_BM 5
`define PMEV_SYNC_RST 9'h1FF

// timing
`define PMEV_CLK_MHZ 100
`define PMEV_DEBOUNCE_MS 16
`define PMEV_DEBOUNCE_CYC (`PMEV_DEBOUNCE_MS * 1000 * `PMEV_CLK_MHZ)
`define PMEV_REARM_CLKS 3'h4

`endif

/* pkg/pmev_pkg.sv */
// Purpose: shared types of the power event block
// Assumes: nothing
// Notes: constants live in pmev_consts.svh
package pmev_pkg;

  typedef enum logic [2:0] {
    PMEV_CS_RUN = 3'b001,
    PMEV_CS_BUS = 3'b010,
    PMEV_CS_PROC = 3'b100
  } pmev_clk_e;

  typedef logic [31:0] pmev_word_t;

endpackage

/* testbench/pmev_partner.sv */
// Purpose: far-side model of the external request source and open-drain line
// Assumes: external pull-up on the request line
// Notes: one go pulse gives one request
`timescale 1ns/100ps
`default_nettype none

module pmev_partner (
  input wire logic pclk,
  input wire logic go,
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic line
);
  logic hold_n = 1'b1;
  int cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  // low two clocks, then high seven before the next request
  always @(posedge pclk) begin
    if (cnt == 0 && go) begin
      cnt <= 8;
      hold_n <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      hold_n <= (cnt < 8);
    end
  end
  // pull-up wins when nobody drives low
  assign line = hold_n & !(dev_oe && !dev_o);
endmodule

`default_nettype wire

/* testbench/pmev_top_test.sv */
// Purpose: self-checking bench of the power event block
// Assumes: short debounce count in simulation
// Notes: random GPO values and request lines from xorshift
`timescale 1ns/100ps
`default_nettype none

`include "pmev_consts.svh"

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end

module pmev_top_test;
  logic pclk = 0, presetn = 0, rrst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_v;
  logic pready, pslverr, rd_e, bat_n = 1, lid = 1, pwr_n = 1, ring_n = 1;
  logic [3:0] bm_n = 4'hF;
  logic ext_line, ext_o, ext_oe, serirq = 0, irq_n, wake, proc_n, bus_n, go = 0;
  logic [31:0] seed = 32'h1282;
  int failures = 0, samples_checked = 0, wakes = 0, n;
  logic [1:0] v;

  pmev_top #(.DEBOUNCE_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .resume_well_reset_n(rrst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .battery_low_n(bat_n), .lid_in(lid), .power_button_n(pwr_n),
    .ring_wake_n(ring_n), .bus_master_req_monitor_n(bm_n),
    .ext_mgmt_irq_req_n_i(ext_line), .ext_mgmt_irq_req_n_o(ext_o),
    .ext_mgmt_irq_req_n_oe(ext_oe), .serirq_mgmt_irq(serirq),
    .mgmt_irq_out_n(irq_n), .resume_wake(wake), .proc_clock_stop_n(proc_n),
    .bus_clock_stop_n(bus_n));
  pmev_partner part_u (.pclk(pclk), .go(go), .dev_o(ext_o), .dev_oe(ext_oe),
    .line(ext_line));

  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake === 1'b1) wakes++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ctrl(input int bits);
    return {21'h0, 11'(bits) | `PMEV_CTRL_RST};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rd_v & m, e)
  endtask
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_n !== 1'b0 && n < 60);
    if (irq_n !== 1'b0) failures++;
  endtask
  task automatic clr();
    apb(1, `PMEV_OFF_STATUS, 32'h1F);
  endtask
  // drive one event pin: 0 lid, 1 power button, else ring
  task automatic drive(input int which, input logic val);
    case (which)
      0: lid <= val;
      1: pwr_n <= val;
      default: ring_n <= val;
    endcase
  endtask
  task automatic pulse(input int which, input int len);
    drive(which, 1'b0);
    repeat (len) @(posedge pclk);
    drive(which, 1'b1);
    repeat (20) @(posedge pclk);
  endtask

  task automatic final_report();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rrst_n <= 1;
    rd(`PMEV_OFF_CTRL, 32'hFFFFFFFF, 32'h600);
    rd(`PMEV_OFF_PINS, 32'h7F5, 32'h1F5);
    apb(0, 12'h00C, 0);
    `CHK({rd_e, rd_v}, 33'h100000000)
    for (int i = 0; i < 4; i++) begin
      v = 2'(rnd());
      apb(1, `PMEV_OFF_CTRL, {21'h0, v, 9'h0});
      repeat (2) @(posedge pclk);
      `CHK({bus_n, proc_n}, v)
    end
    apb(1, `PMEV_OFF_CTRL, ctrl(0));
    go <= 1;
    @(posedge pclk) go <= 0;
    repeat (20) @(posedge pclk);
    `CHK(irq_n, 1'b1)
    clr();
    apb(1, `PMEV_OFF_CTRL, ctrl(1));
    go <= 1;
    @(posedge pclk) go <= 0;
    wait_irq();
    `CHK(irq_n, 1'b0)
    rd(`PMEV_OFF_STATUS, 32'h1, 32'h1);
    clr();
    @(posedge pclk);
    `CHK(irq_n, 1'b1)
    apb(1, `PMEV_OFF_CTRL, ctrl(0));
    serirq <= 1;
    repeat (3) @(posedge pclk);
    `CHK({ext_oe, ext_line}, 2'b10)
    serirq <= 0;
    repeat (3) @(posedge pclk);
    `CHK(ext_oe, 1'b0)
    clr();
    apb(1, `PMEV_OFF_CTRL, ctrl(2));
    pulse(0, 5);
    `CHK(irq_n, 1'b1)
    lid <= 0;
    wait_irq();
    `CHK(irq_n, 1'b0)
    rd(`PMEV_OFF_PINS, 32'h2, 32'h0);
    clr();
    lid <= 1;
    wait_irq();
    `CHK(irq_n, 1'b0)
    clr();
    apb(1, `PMEV_OFF_CTRL, ctrl(12));
    pwr_n <= 0;
    wait_irq();
    @(posedge pclk);
    `CHK(wakes, 1)
    pulse(1, 1);
    clr();
    pulse(2, 3);
    rd(`PMEV_OFF_STATUS, 32'h8, 32'h8);
    `CHK(wakes, 2)
    apb(1, `PMEV_OFF_CTRL, ctrl(28));
    bat_n <= 0;
    repeat (2) @(posedge pclk);
    rd(`PMEV_OFF_PINS, 32'h1, 32'h0);
    pulse(2, 3);
    `CHK(wakes, 2)
    bat_n <= 1;
    clr();
    apb(1, `PMEV_OFF_CTRL, ctrl(0));
    bm_n <= ~(4'h1 << rnd() % 4);
    repeat (6) @(posedge pclk);
    rd(`PMEV_OFF_STATUS, 32'h10, 32'h10);
    bm_n <= 4'hF;
    apb(1, `PMEV_OFF_CTRL, ctrl(11'h140));
    repeat (6) @(posedge pclk);
    `CHK(bus_n, 1'b0)
    apb(1, `PMEV_OFF_CTRL, ctrl(11'h1E0));
    repeat (6) @(posedge pclk);
    `CHK(proc_n, 1'b0)
    rd(`PMEV_OFF_PINS, 32'h700, 32'h400);
    rrst_n <= 0;
    repeat (2) @(posedge pclk);
    `CHK({bus_n, proc_n, irq_n}, 3'b111)
    rrst_n <= 1;
    rd(`PMEV_OFF_STATUS, 32'h1F, 32'h0);
    final_report();
  end
endmodule

`default_nettype wire
